// File: core/sfrb_bank0.sv
// Bank 0 special function registers behind an Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none
module sfrb_bank0
  import sfrb_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic externalResetPinN,
  input wire logic watchdogTimerReset,
  input wire logic [PORT_A_DATA_W-1:0] portAPins,
  input wire logic [7:0] portBPins,
  input wire logic [7:0] portCPins,
  input wire logic pcIncrement,
  input wire logic pcBranch,
  input wire logic [BRANCH_W-1:0] pcBranchTarget,
  output logic [PORT_A_DATA_W-1:0] portALatch,
  output logic [7:0] portBLatch,
  output logic [7:0] portCLatch,
  output logic [PC_W-1:0] programCounter,
  output logic [7:0] coreStatus,
  output logic irq
);

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [7:0] timer0;
    logic [7:0] status;
    logic [7:0] pointer;
    logic [PORT_A_DATA_W-1:0] portALatch;
    logic [7:0] portBLatch;
    logic [7:0] portCLatch;
    logic [PCU_W-1:0] pcUpper;
    logic [7:0] intCtl;
    logic [7:0] pirq;
    logic [7:0] t1Low;
    logic [7:0] t1High;
    logic [7:0] t1Ctl;
    logic [7:0] t2Count;
    logic [7:0] t2Ctl;
    logic [7:0] serial_port_buffer;
    logic [7:0] sspCtl;
    logic [7:0] ccpLow;
    logic [7:0] ccpHigh;
    logic [7:0] ccpCtl;
    logic [EV_W-1:0] evStatus;
    logic [EV_W-1:0] evEnable;
  } sfrb_state_t;

  // Unknown power-on values are forced to zero for determinism
  localparam sfrb_state_t POR_STATE = '{status: STATUS_POR, default: '0};

  sfrb_state_t st;
  sfrb_state_t next_st;

  sfrb_req_if req ();

  logic [SYNC_IN_W-1:0] syncOut;
  logic extPinNSync;
  logic watchdogSync;
  logic [7:0] portCSync;
  logic [7:0] portBSync;
  logic [PORT_A_DATA_W-1:0] portASync;
  logic otherReset;
  logic [INDEX_W-1:0] effIndex;
  logic effBank;
  logic isCommon;
  logic isOwn;
  logic refused;
  logic hit;
  logic [7:0] readValue;
  logic busWrite;
  logic pclWrite;
  logic pcMoveCause;
  logic [EV_W-1:0] evSet;
  logic [EV_W-1:0] evClear;

  // ==========================================================================
  // Bus slave and input synchronisers
  sfrb_avalon_slave u_slave (
    .core_clk(core_clk),
    .resetn(resetn),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .req(req.slave)
  );

  // Watchdog runs from its own oscillator, so it is treated as foreign
  sfrb_sync #(
    .WIDTH(SYNC_IN_W),
    .RESET_VALUE(SYNC_RESET)
  ) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .asyncIn({externalResetPinN, watchdogTimerReset, portCPins, portBPins, portAPins}),
    .syncOut(syncOut)
  );

  assign {extPinNSync, watchdogSync, portCSync, portBSync, portASync} = syncOut;
  assign otherReset = !extPinNSync || watchdogSync;

  // ==========================================================================
  // Decode and read
  always_comb begin
    effIndex = req.index;
    effBank = st.status[STATUS_BANK_LOW_BIT];
    // Indirect slot resolves through the pointer, bank from its top bit
    if (req.index == IDX_INDIRECT) begin
      effIndex = st.pointer[INDEX_W-1:0];
      effBank = st.pointer[7];
    end
    isCommon = effIndex inside {IDX_INDIRECT, IDX_PCL, IDX_STATUS, IDX_POINTER,
                                IDX_PCU, IDX_INTCTL};
    isOwn = effIndex inside {IDX_EV_STATUS, IDX_EV_CLEAR, IDX_EV_ENABLE};
    refused = effBank && !isCommon && !isOwn;
    hit = 1'b1;
    readValue = 8'h00;
    unique case (effIndex)
      IDX_INDIRECT: readValue = 8'h00;
      IDX_TIMER0: readValue = st.timer0;
      IDX_PCL: readValue = st.pc[7:0];
      IDX_STATUS: readValue = st.status;
      IDX_POINTER: readValue = st.pointer;
      IDX_PORT_A_DATA: readValue = {{(8-PORT_A_DATA_W){1'b0}}, portASync};
      IDX_PORT_B_DATA: readValue = portBSync;
      IDX_PORT_C_DATA: readValue = portCSync;
      IDX_PCU: readValue = {{(8-PCU_W){1'b0}}, st.pcUpper};
      IDX_INTCTL: readValue = st.intCtl;
      IDX_PIRQ: readValue = st.pirq & PIRQ_MASK;
      IDX_T1LOW: readValue = st.t1Low;
      IDX_T1HIGH: readValue = st.t1High;
      IDX_T1CTL: readValue = st.t1Ctl & T1CTL_MASK;
      IDX_T2COUNT: readValue = st.t2Count;
      IDX_T2CTL: readValue = st.t2Ctl & T2CTL_MASK;
      IDX_SERIAL_PORT_BUFFER: readValue = st.serial_port_buffer;
      IDX_SSPCTL: readValue = st.sspCtl;
      IDX_CCPLOW: readValue = st.ccpLow;
      IDX_CCPHIGH: readValue = st.ccpHigh;
      IDX_CCPCTL: readValue = st.ccpCtl & CCPCTL_MASK;
      IDX_EV_STATUS: readValue = {{(8-EV_W){1'b0}}, st.evStatus};
      IDX_EV_CLEAR: readValue = 8'h00;
      IDX_EV_ENABLE: readValue = {{(8-EV_W){1'b0}}, st.evEnable};
      default: begin
        hit = 1'b0;
        readValue = 8'h00;
      end
    endcase
    if (refused) begin
      hit = 1'b0;
      readValue = 8'h00;
    end
    req.rdata = readValue;
  end

  // ==========================================================================
  // Next state
  always_comb begin
    next_st = st;
    evClear = '0;
    // A reset in progress swallows the bus write
    busWrite = req.valid && req.write && hit && !otherReset;
    pclWrite = busWrite && (effIndex == IDX_PCL);
    if (busWrite) begin
      unique case (effIndex)
        IDX_TIMER0: next_st.timer0 = req.wdata;
        IDX_STATUS: begin
          // Timeout and power-down flags are read-only
          next_st.status = (st.status & ~STATUS_WRITE_MASK) | (req.wdata & STATUS_WRITE_MASK);
        end
        IDX_POINTER: next_st.pointer = req.wdata;
        IDX_PORT_A_DATA: next_st.portALatch = req.wdata[PORT_A_DATA_W-1:0];
        IDX_PORT_B_DATA: next_st.portBLatch = req.wdata;
        IDX_PORT_C_DATA: next_st.portCLatch = req.wdata;
        IDX_PCU: next_st.pcUpper = req.wdata[PCU_W-1:0];
        IDX_INTCTL: next_st.intCtl = req.wdata;
        IDX_PIRQ: next_st.pirq = req.wdata & PIRQ_MASK;
        IDX_T1LOW: next_st.t1Low = req.wdata;
        IDX_T1HIGH: next_st.t1High = req.wdata;
        IDX_T1CTL: next_st.t1Ctl = req.wdata & T1CTL_MASK;
        IDX_T2COUNT: next_st.t2Count = req.wdata;
        IDX_T2CTL: next_st.t2Ctl = req.wdata & T2CTL_MASK;
        IDX_SERIAL_PORT_BUFFER: next_st.serial_port_buffer = req.wdata;
        IDX_SSPCTL: next_st.sspCtl = req.wdata;
        IDX_CCPLOW: next_st.ccpLow = req.wdata;
        IDX_CCPHIGH: next_st.ccpHigh = req.wdata;
        IDX_CCPCTL: next_st.ccpCtl = req.wdata & CCPCTL_MASK;
        IDX_EV_CLEAR: evClear = req.wdata[EV_W-1:0];
        IDX_EV_ENABLE: next_st.evEnable = req.wdata[EV_W-1:0];
        default: begin
        end
      endcase
    end

    // Upper counter bits load from the holding register on a PCL write, only bits 12:11 on a branch; an increment carries into them
    if (pclWrite) begin
      next_st.pc = {st.pcUpper, req.wdata};
    end else if (pcBranch) begin
      next_st.pc = {st.pcUpper[PCU_W-1 -: PC_W-BRANCH_W], pcBranchTarget};
    end else if (pcIncrement) begin
      next_st.pc = st.pc + 13'h0001;
    end

    if (otherReset) begin
      next_st.pc = '0;
      next_st.pcUpper = '0;
      next_st.status = st.status & STATUS_OTHER_KEEP;
      if (watchdogSync) begin
        next_st.status[STATUS_TIMEOUT_BIT] = 1'b0;
      end
      next_st.intCtl = st.intCtl & INTCTL_OTHER_KEEP;
      next_st.pirq = '0;
      next_st.t2Count = '0;
      next_st.t2Ctl = '0;
      next_st.sspCtl = '0;
      next_st.ccpCtl = '0;
    end

    // Events: a set in the same cycle beats the clear
    evSet = '0;
    evSet[EV_PC_LOAD] = (pclWrite || pcBranch) && !otherReset;
    evSet[EV_UNMAPPED] = req.valid && !hit && !refused;
    evSet[EV_BANK_REFUSED] = req.valid && refused;
    next_st.evStatus = (st.evStatus & ~evClear) | evSet;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st <= POR_STATE;
    end else begin
      st <= next_st;
    end
  end

  assign pcMoveCause = pclWrite || pcBranch || pcIncrement || otherReset;

  // ==========================================================================
  // Outputs
  assign portALatch = st.portALatch;
  assign portBLatch = st.portBLatch;
  assign portCLatch = st.portCLatch;
  assign programCounter = st.pc;
  assign coreStatus = st.status;
  assign irq = |(st.evStatus & st.evEnable);

  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence sBusWrite(logic [INDEX_W-1:0] idx);
    req.valid && req.write && (req.index == idx) && !otherReset;
  endsequence

  sequence sBusRead(logic [INDEX_W-1:0] idx);
    req.valid && !req.write && (req.index == idx);
  endsequence

  AST_COMMON_ANY_BANK:
  assert property (sBusWrite(IDX_PCU) |=> st.pcUpper == $past(req.wdata[PCU_W-1:0]))
    else $error("holding register write lost in a bank");

  AST_UPPER_ONLY_INDIRECT:
  assert property ($changed(st.pc[PC_W-1:8]) |-> $past(pcMoveCause))
    else $error("upper counter bits moved without a load");

  AST_PC_TRANSFER:
  assert property (sBusWrite(IDX_PCL) |=> st.pc == {$past(st.pcUpper), $past(req.wdata)})
    else $error("counter load did not take holding register");

  AST_OTHER_RESET_VALUES:
  assert property (otherReset |=> (st.intCtl[7:1] == 7'h00) && (st.pc == '0)
                   && (st.t1Ctl == $past(st.t1Ctl)) && (st.status[7:5] == 3'h0))
    else $error("other reset values wrong");

  AST_UNMAPPED_ZERO:
  assert property ((req.valid && !req.write && !hit) |-> req.rdata == 8'h00)
    else $error("unimplemented location read not zero");

  AST_PIN_READ:
  assert property ((sBusRead(IDX_PORT_B_DATA) && !st.status[STATUS_BANK_LOW_BIT])
                   |-> req.rdata == portBSync)
    else $error("port read did not return pins");

  AST_LATCH_WRITE:
  assert property ((sBusWrite(IDX_PORT_B_DATA) && !st.status[STATUS_BANK_LOW_BIT])
                   |=> st.portBLatch == $past(req.wdata))
    else $error("port write did not reach latch");

  AST_BANK_REFUSE:
  assert property ((sBusWrite(IDX_PORT_B_DATA) && st.status[STATUS_BANK_LOW_BIT])
                   |=> $stable(st.portBLatch) && st.evStatus[EV_BANK_REFUSED])
    else $error("banked register written while bank 1 selected");

  AST_EVENT_STICKY:
  assert property (evSet[EV_UNMAPPED] |=> st.evStatus[EV_UNMAPPED] [*2])
    else $error("event flag not sticky");

endmodule
`default_nettype wire

// File: core/sfrb_pkg.sv
// Constants shared by the bank 0 special function register block
package sfrb_pkg;

  // ==========================================================================
  // Widths
  localparam int INDEX_W = 7;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;
  localparam int PC_W = 13;
  localparam int PCU_W = 5;
  localparam int BRANCH_W = 11;
  localparam int PORT_A_DATA_W = 6;
  localparam int EV_W = 3;
  localparam int SYNC_IN_W = 24;

  // ==========================================================================
  // Register indices; byte address is four times the index
  localparam logic [INDEX_W-1:0] IDX_INDIRECT = 7'h00;
  localparam logic [INDEX_W-1:0] IDX_TIMER0 = 7'h01;
  localparam logic [INDEX_W-1:0] IDX_PCL = 7'h02;
  localparam logic [INDEX_W-1:0] IDX_STATUS = 7'h03;
  localparam logic [INDEX_W-1:0] IDX_POINTER = 7'h04;
  localparam logic [INDEX_W-1:0] IDX_PORT_A_DATA = 7'h05;
  localparam logic [INDEX_W-1:0] IDX_PORT_B_DATA = 7'h06;
  localparam logic [INDEX_W-1:0] IDX_PORT_C_DATA = 7'h07;
  localparam logic [INDEX_W-1:0] IDX_PCU = 7'h0A;
  localparam logic [INDEX_W-1:0] IDX_INTCTL = 7'h0B;
  localparam logic [INDEX_W-1:0] IDX_PIRQ = 7'h0C;
  localparam logic [INDEX_W-1:0] IDX_T1LOW = 7'h0E;
  localparam logic [INDEX_W-1:0] IDX_T1HIGH = 7'h0F;
  localparam logic [INDEX_W-1:0] IDX_T1CTL = 7'h10;
  localparam logic [INDEX_W-1:0] IDX_T2COUNT = 7'h11;
  localparam logic [INDEX_W-1:0] IDX_T2CTL = 7'h12;
  localparam logic [INDEX_W-1:0] IDX_SERIAL_PORT_BUFFER = 7'h13;
  localparam logic [INDEX_W-1:0] IDX_SSPCTL = 7'h14;
  localparam logic [INDEX_W-1:0] IDX_CCPLOW = 7'h15;
  localparam logic [INDEX_W-1:0] IDX_CCPHIGH = 7'h16;
  localparam logic [INDEX_W-1:0] IDX_CCPCTL = 7'h17;
  localparam logic [INDEX_W-1:0] IDX_EV_STATUS = 7'h20;
  localparam logic [INDEX_W-1:0] IDX_EV_CLEAR = 7'h21;
  localparam logic [INDEX_W-1:0] IDX_EV_ENABLE = 7'h22;

  // ==========================================================================
  // Field positions and masks
  localparam int STATUS_INDIRECT_BANK_BIT = 7;
  localparam int STATUS_BANK_HIGH_BIT = 6;
  localparam int STATUS_BANK_LOW_BIT = 5;
  localparam int STATUS_TIMEOUT_BIT = 4;
  localparam int STATUS_POWERDOWN_BIT = 3;
  localparam logic [7:0] STATUS_WRITE_MASK = 8'hE7;
  localparam logic [7:0] STATUS_OTHER_KEEP = 8'h1F;
  localparam logic [7:0] INTCTL_OTHER_KEEP = 8'h01;
  localparam logic [7:0] PIRQ_MASK = 8'hCF;
  localparam logic [7:0] T1CTL_MASK = 8'h3F;
  localparam logic [7:0] T2CTL_MASK = 8'h7F;
  localparam logic [7:0] CCPCTL_MASK = 8'h3F;
  localparam int EV_PC_LOAD = 0;
  localparam int EV_UNMAPPED = 1;
  localparam int EV_BANK_REFUSED = 2;

  // ==========================================================================
  // Values after reset
  localparam logic [7:0] STATUS_POR = 8'h18;
  localparam logic [SYNC_IN_W-1:0] SYNC_RESET = 24'h800000;

endpackage

// File: core/sfrb_req_if.sv
// Request and answer between the bus slave and the register bank
`timescale 1ns/1ps
`default_nettype none
interface sfrb_req_if;
  import sfrb_pkg::*;
  logic valid;
  logic write;
  logic [INDEX_W-1:0] index;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport slave (output valid, output write, output index, output wdata, input rdata);
  modport bank (input valid, input write, input index, input wdata, output rdata);
endinterface
`default_nettype wire

// File: core/sfrb_sync.sv
// Two flip-flop synchroniser for pins and foreign reset sources
`timescale 1ns/1ps
`default_nettype none
module sfrb_sync
  import sfrb_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sfrb_sync_t;

  sfrb_sync_t st;
  sfrb_sync_t next_st;

  // First stage feeds only the second
  always_comb begin
    next_st.stage1 = asyncIn;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st <= {RESET_VALUE, RESET_VALUE};
    end else begin
      st <= next_st;
    end
  end

  assign syncOut = st.stage2;

endmodule
`default_nettype wire

// File: core/sfrb_avalon_slave.sv
// Avalon-MM slave with one wait state in front of the register bank
`timescale 1ns/1ps
`default_nettype none
module sfrb_avalon_slave
  import sfrb_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  sfrb_req_if.slave req
);

  typedef struct packed {
    logic ack;
    logic [DATA_W-1:0] readData;
  } sfrb_slave_t;

  sfrb_slave_t st;
  sfrb_slave_t next_st;
  logic request;

  // ==========================================================================
  // Handshake
  // Read data are captured a cycle early so they leave a flip-flop
  always_comb begin
    request = avs_read || avs_write;
    next_st = st;
    next_st.ack = request && !st.ack;
    if (request && !st.ack) begin
      next_st.readData = {{(DATA_W-8){1'b0}}, req.rdata};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Only byte lane 0 carries data; other lanes are ignored
  assign avs_waitrequest = request && !st.ack;
  assign avs_readdata = st.readData;
  assign req.valid = st.ack && (avs_read || (avs_write && avs_byteenable[0]));
  assign req.write = avs_write;
  assign req.index = avs_address[ADDR_W-1:2];
  assign req.wdata = avs_writedata[7:0];

  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence sNewRequest;
    request && !st.ack;
  endsequence

  AST_ONE_WAIT_STATE:
  assert property (sNewRequest |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("request not answered after one wait state");

endmodule
`default_nettype wire

// File: test/sfrb_core_model.sv
// Behavioural model of the processor core beside the bank 0 register block
`timescale 1ns/1ps
`default_nettype none
module sfrb_core_model
  import sfrb_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic branchReq,
  input wire logic stepReq,
  input wire logic [BRANCH_W-1:0] target,
  input wire logic [INDEX_W-1:0] wrIndex,
  input wire logic [7:0] wrRaw,
  output logic pcIncrement,
  output logic pcBranch,
  output logic [BRANCH_W-1:0] pcBranchTarget,
  output logic [7:0] wrSafe
);
  // ==========================================================================
  // Program counter strobes, one cycle behind the request
  always_ff @(posedge core_clk) begin
    pcIncrement <= resetn & stepReq;
    pcBranch <= resetn & branchReq;
    // Idle target toggles so a stray branch never hits a stable value
    pcBranchTarget <= !resetn ? 11'h000 : (branchReq ? target : ~pcBranchTarget);
  end

  // ==========================================================================
  // Software keeps bits 7:6 clear in what it writes to STATUS and PIRQ
  always_comb begin
    wrSafe = wrRaw;
    if (wrIndex == IDX_STATUS) begin
      wrSafe[7:6] = 2'h0;
    end
    if (wrIndex == IDX_PIRQ) begin
      wrSafe[7:6] = 2'h0;
    end
  end
endmodule
`default_nettype wire

// File: test/test_special_function_register_bank0.sv
// Self-checking bench for the bank 0 register block
`timescale 1ns/1ps
`default_nettype none
module test_special_function_register_bank0
  import sfrb_pkg::*;
;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic externalResetPinN = 1'b1;
  logic watchdogTimerReset = 1'b0;
  logic [PORT_A_DATA_W-1:0] portAPins = '0;
  logic [7:0] portBPins = 8'h00;
  logic [7:0] portCPins = 8'h00;
  logic pcIncrement, pcBranch;
  logic [BRANCH_W-1:0] pcBranchTarget;
  logic [PORT_A_DATA_W-1:0] portALatch;
  logic [7:0] portBLatch, portCLatch, coreStatus, wrSafe, e;
  logic [PC_W-1:0] programCounter;
  logic irq;
  logic branchReq = 1'b0;
  logic stepReq = 1'b0;
  logic [BRANCH_W-1:0] target = '0;
  logic [INDEX_W-1:0] wrIndex = '0;
  logic [7:0] wrRaw = 8'h00;
  logic [31:0] seed = 32'h0001421E;
  logic [7:0] shadow [0:127];
  int nFail = 0;
  int samplesChecked = 0;
  localparam logic [INDEX_W-1:0] WL [19] = '{IDX_TIMER0, IDX_STATUS, IDX_POINTER, IDX_PORT_A_DATA,
    IDX_PORT_B_DATA, IDX_PORT_C_DATA, IDX_PCU, IDX_INTCTL, IDX_PIRQ, IDX_T1LOW, IDX_T1HIGH, IDX_T1CTL,
    IDX_T2COUNT, IDX_T2CTL, IDX_SERIAL_PORT_BUFFER, IDX_SSPCTL, IDX_CCPLOW, IDX_CCPHIGH, IDX_CCPCTL};

  always #5 core_clk = ~core_clk;

  sfrb_bank0 i_dut (.core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .externalResetPinN(externalResetPinN),
    .watchdogTimerReset(watchdogTimerReset), .portAPins(portAPins), .portBPins(portBPins),
    .portCPins(portCPins), .pcIncrement(pcIncrement), .pcBranch(pcBranch),
    .pcBranchTarget(pcBranchTarget), .portALatch(portALatch), .portBLatch(portBLatch),
    .portCLatch(portCLatch), .programCounter(programCounter), .coreStatus(coreStatus),
    .irq(irq));

  sfrb_core_model i_core (.core_clk(core_clk), .resetn(resetn), .branchReq(branchReq),
    .stepReq(stepReq), .target(target), .wrIndex(wrIndex), .wrRaw(wrRaw),
    .pcIncrement(pcIncrement), .pcBranch(pcBranch), .pcBranchTarget(pcBranchTarget),
    .wrSafe(wrSafe));

  // ==========================================================================
  // Expectations
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] kept(input logic [INDEX_W-1:0] idx, input logic [7:0] d);
    case (idx)
      IDX_STATUS: kept = (d & STATUS_WRITE_MASK) | STATUS_POR;
      IDX_PCU: kept = d & 8'h1F;
      IDX_PIRQ: kept = d & PIRQ_MASK;
      IDX_T1CTL: kept = d & T1CTL_MASK;
      IDX_T2CTL: kept = d & T2CTL_MASK;
      IDX_CCPCTL: kept = d & CCPCTL_MASK;
      IDX_PORT_A_DATA: kept = d & 8'h3F;
      default: kept = d;
    endcase
  endfunction

  function automatic logic [7:0] pinVal(input logic [INDEX_W-1:0] idx);
    case (idx)
      IDX_PORT_A_DATA: pinVal = {2'h0, portAPins};
      IDX_PORT_B_DATA: pinVal = portBPins;
      default: pinVal = portCPins;
    endcase
  endfunction

  // ==========================================================================
  // Checks and bus cycles; every task is entered just after a rising edge
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [INDEX_W-1:0] idx, input logic [7:0] d,
                     input logic be, output logic [31:0] q);
    avs_address <= {idx, 2'h0};
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= {3'h0, be};
    avs_write <= w;
    avs_read <= !w;
    // Sampled at the rising edge itself; a hang is left to the watchdog
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [INDEX_W-1:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, 1'b1, q);
  endtask

  task automatic rd(input logic [INDEX_W-1:0] idx, input logic [7:0] x);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, 1'b1, q);
    check(q, {24'h000000, x});
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    nFail++;
    end_of_test();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    seed = lfsr(seed);
    portAPins <= seed[5:0];
    portBPins <= seed[13:6];
    portCPins <= seed[21:14];
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      e = 8'h00;
      if (i == IDX_STATUS) e = STATUS_POR;
      if (i >= IDX_PORT_A_DATA && i <= IDX_PORT_C_DATA) e = pinVal(7'(i));
      rd(7'(i), e);
    end
    foreach (WL[k]) begin
      seed = lfsr(seed);
      wrIndex <= WL[k];
      wrRaw <= seed[7:0] & ((WL[k] == IDX_STATUS) ? 8'hDF : 8'hFF);
      @(posedge core_clk);
      shadow[WL[k]] = kept(WL[k], wrSafe);
      wr(WL[k], wrSafe);
    end
    foreach (WL[k]) begin
      e = shadow[WL[k]];
      if (WL[k] inside {IDX_PORT_A_DATA, IDX_PORT_B_DATA, IDX_PORT_C_DATA}) e = pinVal(WL[k]);
      rd(WL[k], e);
    end
    check(32'(portALatch), 32'(shadow[IDX_PORT_A_DATA]));
    check(32'(portBLatch), 32'(shadow[IDX_PORT_B_DATA]));
    check(32'(portCLatch), 32'(shadow[IDX_PORT_C_DATA]));
    begin : lane_off
      logic [31:0] q;
      bus(1'b1, IDX_T2COUNT, ~shadow[IDX_T2COUNT], 1'b0, q);
    end
    rd(IDX_T2COUNT, shadow[IDX_T2COUNT]);
    wr(IDX_POINTER, 8'h0A);
    rd(IDX_INDIRECT, shadow[IDX_PCU]);
    // Program counter: holding feeds the upper bits only on a load
    wr(IDX_PCU, 8'h15);
    check(32'(programCounter[12:8]), 32'h00000000);
    wr(IDX_PCL, 8'h34);
    check(32'(programCounter), 32'h00001534);
    rd(IDX_PCL, 8'h34);
    target <= 11'h2AB;
    branchReq <= 1'b1;
    @(posedge core_clk);
    branchReq <= 1'b0;
    repeat (3) @(posedge core_clk);
    check(32'(programCounter), 32'h000012AB);
    stepReq <= 1'b1;
    repeat (4) @(posedge core_clk);
    stepReq <= 1'b0;
    repeat (3) @(posedge core_clk);
    check(32'(programCounter), 32'h000012AF);
    // Events and the interrupt line
    wr(IDX_EV_CLEAR, 8'h07);
    rd(IDX_EV_STATUS, 8'h00);
    rd(IDX_EV_CLEAR, 8'h00);
    wr(IDX_EV_ENABLE, 8'h01 << EV_UNMAPPED);
    check(32'(irq), 32'h0);
    rd(7'h1C, 8'h00);
    check(32'(irq), 32'h1);
    rd(IDX_EV_STATUS, 8'h01 << EV_UNMAPPED);
    wr(IDX_EV_ENABLE, 8'h00);
    check(32'(irq), 32'h0);
    wr(IDX_EV_ENABLE, 8'h01 << EV_UNMAPPED);
    check(32'(irq), 32'h1);
    wr(IDX_EV_CLEAR, 8'h01 << EV_UNMAPPED);
    check(32'(irq), 32'h0);
    // Bank select low set: only the common set and the event registers answer
    wr(IDX_STATUS, 8'h20);
    rd(IDX_STATUS, 8'h38);
    rd(IDX_PORT_B_DATA, 8'h00);
    wr(IDX_PORT_B_DATA, ~shadow[IDX_PORT_B_DATA]);
    check(32'(portBLatch), 32'(shadow[IDX_PORT_B_DATA]));
    rd(IDX_PCU, 8'h15);
    rd(IDX_EV_STATUS, 8'h01 << EV_BANK_REFUSED);
    wr(IDX_STATUS, 8'h00);
    rd(IDX_STATUS, STATUS_POR);
    // Watchdog then pin reset load the other-reset values
    watchdogTimerReset <= 1'b1;
    @(posedge core_clk);
    watchdogTimerReset <= 1'b0;
    repeat (4) @(posedge core_clk);
    check(32'(programCounter), 32'h0);
    check(32'(coreStatus), 32'h08);
    rd(IDX_PCU, 8'h00);
    rd(IDX_TIMER0, shadow[IDX_TIMER0]);
    rd(IDX_INTCTL, shadow[IDX_INTCTL] & INTCTL_OTHER_KEEP);
    rd(IDX_T2COUNT, 8'h00);
    wr(IDX_PCU, 8'h0F);
    externalResetPinN <= 1'b0;
    @(posedge core_clk);
    externalResetPinN <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(IDX_PCU, 8'h00);
    rd(IDX_STATUS, 8'h08);
    rd(IDX_PIRQ, 8'h00);
    check(32'(portBLatch), 32'(shadow[IDX_PORT_B_DATA]));
    end_of_test();
  end
endmodule
`default_nettype wire
